// [design/gpib_addr_defs.vh]
// Constants for the bus address decoder
`ifndef GPIB_ADDR_DEFS_VH
`define GPIB_ADDR_DEFS_VH

`define ADDR_FIELD_LSB    0
`define ADDR_FIELD_MSB    4
`define LISTEN_BIT        5
`define TALK_BIT          6
`define GROUP_LSB         5
`define GROUP_MSB         6
`define GROUP_LISTEN      2'h1
`define GROUP_TALK        2'h2
`define GROUP_SECONDARY   2'h3
`define ADDR_NONE         5'h1f
`define MAX_ADDR          5'h1e
`define CMD_UNLISTEN      7'h3f
`define CMD_UNTALK        7'h5f
`define LISTEN_OFFSET     7'h20
`define TALK_OFFSET       7'h40
`define SECONDARY_OFFSET  7'h60

`endif

// [design/gpib_address_decoder.v]
// Talker and listener address decoder for a bus instrument
`include "gpib_addr_defs.vh"
`default_nettype none

module gpib_address_decoder #(
    parameter [4:0] PRIMARY_ADDR   = 5'h01,
    parameter [4:0] SECONDARY_ADDR = 5'h00,
    parameter       USE_SECONDARY  = 0
) (
    input  wire       clk,
    input  wire       rst,
    input  wire [4:0] my_primary,
    input  wire [4:0] my_secondary,
    input  wire       secondary_en,
    input  wire [7:0] dio_in,
    input  wire       atn_in,
    input  wire       ifc_in,
    input  wire       dav_in,
    input  wire       accept_done,
    output reg        nrfd_out,
    output reg        nrfd_oe,
    output reg        ndac_out,
    output reg        ndac_oe,
    output reg        talk_en,
    output reg        listen_en,
    output reg        data_strobe,
    output reg  [7:0] data_byte,
    output reg        cmd_strobe,
    output reg  [6:0] cmd_byte
);

// ----------------------------------------------------------------
// Input synchronisers
// ----------------------------------------------------------------
reg  [7:0] dio_s1;
reg  [7:0] dio_s2;
reg  [2:0] ctl_s1;
reg  [2:0] ctl_s2;
wire       atn = ctl_s2[2];
wire       ifc = ctl_s2[1];
wire       dav = ctl_s2[0];

always @(posedge clk or posedge rst) begin
    if (rst) begin
        dio_s1 <= 8'h00;
        dio_s2 <= 8'h00;
        ctl_s1 <= 3'h0;
        ctl_s2 <= 3'h0;
    end else begin
        dio_s1 <= dio_in;
        dio_s2 <= dio_s1;
        ctl_s1 <= {atn_in, ifc_in, dav_in};
        ctl_s2 <= ctl_s1;
    end
end

// ----------------------------------------------------------------
// Configured addresses
// ----------------------------------------------------------------
// Settings are sampled after reset release; 1Fh is clamped because it
// would alias the unaddress commands.
reg  [4:0] own_pri;
reg  [4:0] own_sec;
reg        own_sec_en;
reg        cfg_loaded;

always @(posedge clk or posedge rst) begin
    if (rst) begin
        own_pri    <= PRIMARY_ADDR;
        own_sec    <= SECONDARY_ADDR;
        own_sec_en <= 1'b0;
        cfg_loaded <= 1'b0;
    end else if (!cfg_loaded) begin
        cfg_loaded <= 1'b1;
        own_pri    <= (my_primary > `MAX_ADDR) ? `MAX_ADDR
                                               : my_primary;
        own_sec    <= (my_secondary > `MAX_ADDR) ? `MAX_ADDR
                                                 : my_secondary;
        own_sec_en <= secondary_en | (USE_SECONDARY != 0);
    end
end

// ----------------------------------------------------------------
// Command decode
// ----------------------------------------------------------------
wire [6:0] cmd    = dio_s2[6:0];
wire [4:0] field  = cmd[`ADDR_FIELD_MSB:`ADDR_FIELD_LSB];
wire [1:0] group  = cmd[`GROUP_MSB:`GROUP_LSB];
wire       is_unl = (cmd == `CMD_UNLISTEN);
wire       is_unt = (cmd == `CMD_UNTALK);
wire       addr_ok = (field != `ADDR_NONE);
wire       mla    = (cmd == `LISTEN_OFFSET + {2'b00, own_pri});
wire       mta    = (cmd == `TALK_OFFSET + {2'b00, own_pri});
wire       ota    = (group == `GROUP_TALK) && addr_ok && !mta;
wire       msa    = (cmd == `SECONDARY_OFFSET + {2'b00, own_sec});
wire       is_sec = (group == `GROUP_SECONDARY) && addr_ok;

// ----------------------------------------------------------------
// Acceptor handshake
// ----------------------------------------------------------------
localparam [1:0] ST_IDLE   = 2'd0;
localparam [1:0] ST_TAKE   = 2'd1;
localparam [1:0] ST_WAIT   = 2'd2;
localparam [1:0] ST_RELEASE = 2'd3;

reg  [1:0] state;
reg        pend_listen;
reg        pend_talk;
// During commands every device joins the handshake; with ATN low only a
// listener does, so an unaddressed device never holds the bus up.
wire       active = atn || listen_en;

always @(posedge clk or posedge rst) begin
    if (rst) begin
        state       <= ST_IDLE;
        nrfd_out    <= 1'b0;
        nrfd_oe     <= 1'b0;
        ndac_out    <= 1'b0;
        ndac_oe     <= 1'b0;
        talk_en     <= 1'b0;
        listen_en   <= 1'b0;
        pend_listen <= 1'b0;
        pend_talk   <= 1'b0;
        data_strobe <= 1'b0;
        data_byte   <= 8'h00;
        cmd_strobe  <= 1'b0;
        cmd_byte    <= 7'h00;
    end else if (ifc) begin
        state       <= ST_IDLE;
        talk_en     <= 1'b0;
        listen_en   <= 1'b0;
        pend_listen <= 1'b0;
        pend_talk   <= 1'b0;
        nrfd_oe     <= 1'b0;
        ndac_oe     <= 1'b0;
        data_strobe <= 1'b0;
        cmd_strobe  <= 1'b0;
    end else begin
        data_strobe <= 1'b0;
        cmd_strobe  <= 1'b0;
        // Open-drain lines: drive low to assert
        nrfd_out <= 1'b0;
        ndac_out <= 1'b0;
        case (state)
        ST_IDLE: begin
            nrfd_oe <= 1'b0;
            ndac_oe <= active;
            if (active && dav) begin
                state   <= ST_TAKE;
                nrfd_oe <= 1'b1;
            end
        end
        ST_TAKE: begin
            nrfd_oe <= 1'b1;
            ndac_oe <= 1'b1;
            state   <= ST_WAIT;
            if (atn) begin
                cmd_strobe <= 1'b1;
                cmd_byte   <= cmd;
                if (is_unl) begin
                    listen_en   <= 1'b0;
                    pend_listen <= 1'b0;
                    pend_talk   <= 1'b0;
                end else if (is_unt) begin
                    talk_en     <= 1'b0;
                    pend_talk   <= 1'b0;
                    pend_listen <= 1'b0;
                end else if (mla) begin
                    if (own_sec_en) begin
                        pend_listen <= 1'b1;
                    end else begin
                        listen_en <= 1'b1;
                    end
                    pend_talk <= 1'b0;
                end else if (mta) begin
                    if (own_sec_en) begin
                        pend_talk <= 1'b1;
                    end else begin
                        talk_en <= 1'b1;
                    end
                    pend_listen <= 1'b0;
                end else if (ota) begin
                    talk_en     <= 1'b0;
                    pend_talk   <= 1'b0;
                    pend_listen <= 1'b0;
                end else if (is_sec) begin
                    if (msa && pend_listen) begin
                        listen_en <= 1'b1;
                    end
                    if (msa && pend_talk) begin
                        talk_en <= 1'b1;
                    end
                    pend_listen <= 1'b0;
                    pend_talk   <= 1'b0;
                end else begin
                    pend_listen <= 1'b0;
                    pend_talk   <= 1'b0;
                end
            end else if (listen_en) begin
                data_strobe <= 1'b1;
                data_byte   <= dio_s2;
            end
        end
        ST_WAIT: begin
            // Hold NDAC until the user side has consumed a data byte
            if (atn || accept_done) begin
                ndac_oe <= 1'b0;
                state   <= ST_RELEASE;
            end
        end
        default: begin
            ndac_oe <= 1'b0;
            if (!dav) begin
                ndac_oe <= active;
                nrfd_oe <= 1'b0;
                state   <= ST_IDLE;
            end
        end
        endcase
    end
end

endmodule
`default_nettype wire

// [test/gpib_addr_chk.sv]
// Checker of addressing behaviour at the decoder ports
`default_nettype none
module gpib_addr_chk (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [4:0] my_primary,
    input wire logic       secondary_en,
    input wire logic       ifc_in,
    input wire logic       talk_en,
    input wire logic       listen_en,
    input wire logic       nrfd_oe,
    input wire logic       ndac_oe,
    input wire logic       nrfd_out,
    input wire logic       ndac_out,
    input wire logic       cmd_strobe,
    input wire logic [6:0] cmd_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    // Own address as the decoder holds it, clamped to the legal range
    wire [4:0] pe = (my_primary > 5'h1e) ? 5'h1e : my_primary;
    wire       c = cmd_strobe && cmd_byte[4:0] != 5'h1f;
    wire [1:0] g = cmd_byte[6:5];
    wire       o = cmd_byte[4:0] == pe;
    wire       m = c && o && !secondary_en;
    wire       u = cmd_strobe && cmd_byte == 7'h3f;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_ol; m && g == 2'h1 |-> listen_en; endproperty
    a_ol: assert property (p_ol) else $error("no listen");
    property p_ot; m && g == 2'h2 |-> talk_en; endproperty
    a_ot: assert property (p_ot) else $error("no talk");
    property p_xt; cmd_strobe && g == 2'h2 && !o |-> !talk_en; endproperty
    a_xt: assert property (p_xt) else $error("talk kept");
    property p_ul; u |-> !listen_en; endproperty
    a_ul: assert property (p_ul) else $error("listen kept");
    // Only unlisten or interface clear may drop a listener
    property p_kl;
        $fell(listen_en) |-> u || $past(ifc_in, 3) || $past(ifc_in, 4);
    endproperty
    a_kl: assert property (p_kl) else $error("listen lost");
    property p_rt; $rose(talk_en) |-> c && cmd_byte[6]; endproperty
    a_rt: assert property (p_rt) else $error("bad talk");
    property p_rl; $rose(listen_en) |-> c && cmd_byte[5]; endproperty
    a_rl: assert property (p_rl) else $error("bad lstn");
    // Command taken only while both handshake lines are pulled low
    property p_hs;
        cmd_strobe |-> nrfd_oe && ndac_oe && !nrfd_out && !ndac_out;
    endproperty
    a_hs: assert property (p_hs) else $error("no hold");
    property p_if; ifc_in [*4] |=> !talk_en && !listen_en; endproperty
    a_if: assert property (p_if) else $error("clear failed");
    cover property (m && g == 2'h1);
    cover property ($rose(talk_en));
    cover property (u && $past(listen_en));
endmodule
bind gpib_address_decoder gpib_addr_chk i_gpib_addr_chk (.*);
`default_nettype wire

// [test/gpib_ctrl_model.sv]
// Bus controller model sending bytes by the three-wire handshake
`default_nettype none
module gpib_ctrl_model (
    input  wire logic       clk,
    input  wire logic       nrfd_oe,
    input  wire logic       ndac_oe,
    output var  logic [7:0] dio = 8'h00,
    output var  logic       atn = 1'b0,
    output var  logic       dav = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    // Lone listener on the wire, so line level follows its enable
    task automatic send(input logic [7:0] b, input logic a, input int w);
        repeat (w + 1) @(posedge clk);
        dio <= b;
        atn <= a; // Sole controller in charge
        @(posedge clk);
        dav <= 1'b1;
        repeat (6) @(posedge clk);
        for (int i = 0; i < 40 && ndac_oe; i++) @(posedge clk);
        dav <= 1'b0;
        dio <= ~b; // Released lines must not keep the old byte
        repeat (4) @(posedge clk);
        for (int i = 0; i < 40 && nrfd_oe; i++) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// [test/tb.sv]
// Random and corner-case bench for the bus address decoder
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rst = 1, ifc = 0, se = 0, acc = 0;
    logic [4:0]  pa = 5'h05, sa = 5'h03;
    logic [7:0]  dio, dbyte, got;
    logic        atn, dav, nrfd_oe, ndac_oe, talk_en, listen_en, dstb;
    logic [3:0]  s = 4'h0;
    logic [31:0] seed = 32'h12ff_85dc;
    int          error_cnt = 0, cmp_count = 0, ndat = 0;
    logic [7:0]  cc [9] = '{8'h25, 8'h26, 8'h3f, 8'ha5, 8'h45, 8'h41,
                            8'hc5, 8'h5f, 8'h3f};
    logic [7:0]  sc [13] = '{8'h25, 8'h63, 8'h3f, 8'h25, 8'h64, 8'h45,
                             8'h63, 8'h41, 8'h25, 8'h01, 8'h63, 8'h25, 8'h63};
    gpib_address_decoder i_gpib_address_decoder (
        .clk(clk), .rst(rst), .my_primary(pa), .my_secondary(sa),
        .secondary_en(se), .dio_in(dio), .atn_in(atn), .ifc_in(ifc),
        .dav_in(dav), .accept_done(acc), .nrfd_out(), .nrfd_oe(nrfd_oe),
        .ndac_out(), .ndac_oe(ndac_oe), .talk_en(talk_en),
        .listen_en(listen_en), .data_strobe(dstb), .data_byte(dbyte),
        .cmd_strobe(), .cmd_byte());
    gpib_ctrl_model i_gpib_ctrl_model (.clk(clk), .nrfd_oe(nrfd_oe),
        .ndac_oe(ndac_oe), .dio(dio), .atn(atn), .dav(dav));
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    // State is {talker, listener, talk pending, listen pending}
    function automatic logic [3:0] nxt(input logic [3:0] q, logic [6:0] c);
        logic o;
        o = c[4:0] == pa;
        if (c[6:5] == 2'h3 && c[4:0] == sa) begin
            q[3:2] |= q[1:0];
        end
        if (se || c[6:5] == 2'h3) q[1:0] = 2'h0;
        if (c == 7'h3f) q[2] = 1'b0;
        else if (c[6:5] == 2'h1 && o) q[se ? 0 : 2] = 1'b1;
        else if (c[6:5] == 2'h2 && !o) q[3] = 1'b0;
        else if (c[6:5] == 2'h2) q[se ? 1 : 3] = 1'b1;
        return q;
    endfunction
    task automatic chk(input logic [7:0] g, e);
        cmp_count++;
        if (g !== e) begin
            $display("CHECK FAILED at %0t: got %h exp %h", $time, g, e);
            error_cnt++;
        end
    endtask
    task automatic cmd(input logic [7:0] c);
        i_gpib_ctrl_model.send(c, 1'b1, seed[2:0]);
        s = nxt(s, c[6:0]);
        @(posedge clk);
        chk({6'h0, talk_en, listen_en}, {6'h0, s[3:2]});
    endtask
    task automatic dat(input logic [7:0] d);
        int n;
        n = ndat;
        i_gpib_ctrl_model.send(d, 1'b0, seed[1:0]);
        @(posedge clk);
        chk(8'(ndat - n), {7'h0, s[2]});
        if (s[2]) chk(got, d);
    endtask
    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial forever #4 clk = ~clk;
    always @(posedge clk) begin
        seed <= xs(seed);
        acc <= seed[3];
        if (dstb === 1'b1) begin
            got <= dbyte;
            ndat <= ndat + 1;
        end
    end
    initial begin
        #300us;
        error_cnt++;
        end_sim();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        foreach (cc[i]) begin
            cmd(cc[i]);
            dat(seed[15:8]);
        end
        $display("corner test done");
        repeat (120) begin
            if (seed[4]) dat(seed[15:8]);
            else cmd({1'b0, seed[6:5], seed[7] ? pa : seed[12:8]});
        end
        $display("random test done");
        cmd(8'h25);
        cmd(8'h45);
        ifc <= 1'b1;
        repeat (4) @(posedge clk);
        ifc <= 1'b0;
        repeat (4) @(posedge clk);
        s = 4'h0;
        chk({6'h0, talk_en, listen_en}, 8'h00);
        $display("clear test done");
        // Secondary mode is latched only after a reset
        rst <= 1'b1;
        se <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        foreach (sc[i]) cmd(sc[i]);
        dat(8'h5a);
        $display("secondary test done");
        end_sim();
    end
endmodule
`default_nettype wire
